// ---- rtl/rsdc_pkg.sv ----
// Notes on behaviour
// - Each word: read flag, 15-bit address, 16-bit data.
// - Master changes write line on serial clock fall.
// - Master samples readback line on serial clock rise.
// - Words travel most significant bit first, flag leading.
// - Serial clock stays idle between command words.
// - After reset, third generated clock runs 10 MHz.
// - Serial functions only on pins one to three.
// - Each of 16 pins is input or output.
// - Output pins choose serial, trigger, generator or register.
// - Input pins feed readback, trigger or status register.
// - Another pin may carry the serial generator clock.
// - Two master sources: fixed 25 MHz, tunable 80-230 MHz.
// - First generated clock uses a 10-bit divider.
// - Second and third use 7-bit dividers.
// - Generated clocks reach any pin and trigger lines.
package rsdc_pkg;
	localparam int WORD_W = 32;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 16;
	localparam int CMD_RW = 31;
	localparam logic [5:0] SPI_BITS = 6'h20;
	localparam int NPINS = 16;
	localparam int NPCH = 8;
	localparam int NTRIG = 8;
	localparam int PIN_SCLK = 0;
	localparam int PIN_MOSI = 1;
	localparam logic [2:0] PIN_MISO = 3'h2;
	localparam int GEN1_W = 10;
	localparam int GEN23_W = 7;
	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_TX = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_RX = 8'h0c;
	localparam logic [7:0] ADR_GEN1 = 8'h10;
	localparam logic [7:0] ADR_GEN2 = 8'h14;
	localparam logic [7:0] ADR_GEN3 = 8'h18;
	localparam logic [7:0] ADR_TRIG = 8'h1c;
	localparam logic [7:0] ADR_DOUT = 8'h20;
	localparam logic [7:0] ADR_DIN = 8'h24;
	localparam logic [7:0] ADR_PIN0 = 8'h28;
	localparam logic [7:0] ADR_PINL = 8'h64;
	localparam int CTRL_CHAN = 0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_EMPTY = 1;
	localparam int STAT_FULL = 2;
	// ----------------------------------------
	// Clock rates, divider output = source / (2 * div)
	// ----------------------------------------
	localparam int FIXED_SRC_KHZ = 25000;
	localparam int TUNE_MIN_KHZ = 80000;
	localparam int TUNE_MAX_KHZ = 230000;
	localparam int SPI_RST_KHZ = 10000;
	localparam logic [9:0] GEN3_RST_DIV = 10'(TUNE_MIN_KHZ / (2 * SPI_RST_KHZ));
	localparam logic [9:0] GEN_RST_DIV = 10'h001;
	typedef enum logic [2:0] {
		OSEL_REG, OSEL_SCLK, OSEL_MOSI, OSEL_TRIG, OSEL_GEN1, OSEL_GEN2, OSEL_GEN3
	} rsdc_osel_t;
	typedef struct packed {
		logic trig_en;
		logic [2:0] tsel;
		rsdc_osel_t osel;
		logic drive;
	} rsdc_pin_cfg_t;
	typedef struct packed {
		logic src_tune;
		logic [9:0] div;
	} rsdc_gen_cfg_t;
	localparam rsdc_pin_cfg_t PIN_CFG_RST = '{1'b0, 3'h0, OSEL_REG, 1'b0};
	localparam rsdc_gen_cfg_t GEN_RST = '{1'b0, GEN_RST_DIV};
	localparam rsdc_gen_cfg_t GEN3_RST = '{1'b1, GEN3_RST_DIV};
endpackage

// ---- rtl/rsdc_fifo.sv ----
module rsdc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Status
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic ov_q, ov_d;
	logic [WIDTH-1:0] od_q, od_d;
	logic push, pull;

	always_comb begin
		in_ready = cnt_q != (AW+1)'(DEPTH);
		push = in_valid && in_ready;
		// Output register refills whenever it is empty or being taken
		pull = (cnt_q != '0) && (!ov_q || out_ready);
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pull ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pull);
		ov_d = pull || (ov_q && !out_ready);
		od_d = pull ? mem[rd_q] : od_q;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ov_q <= ov_d;
			od_q <= od_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	assign out_valid = ov_q;
	assign out_data = od_q;
	assign full = !in_ready;
	assign empty = !ov_q && (cnt_q == '0);
endmodule

// ---- rtl/rsdc_divider.sv ----
module rsdc_divider #(
	parameter int DIV_W = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Master source ticks
	input wire logic tick_fixed,
	input wire logic tick_tune,
	// Setting
	input wire logic src_tune,
	input wire logic [DIV_W-1:0] div,
	input wire logic [DIV_W-1:0] rst_div,
	// Generated clock level
	output logic clk_out
);
	logic [DIV_W-1:0] cnt_q, cnt_d;
	logic lvl_q, lvl_d;
	logic tick;
	logic [DIV_W-1:0] lim;

	always_comb begin
		tick = src_tune ? tick_tune : tick_fixed;
		// Zero setting falls back to the given divide rather than stalling
		lim = (div == '0) ? rst_div : div;
		cnt_d = cnt_q;
		lvl_d = lvl_q;
		if (tick) begin
			if (cnt_q >= lim - 1'b1) begin
				cnt_d = '0;
				lvl_d = !lvl_q;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			lvl_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			lvl_q <= lvl_d;
		end
	end

	assign clk_out = lvl_q;
endmodule

// ---- rtl/rsdc_top.sv ----
module rsdc_top #(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Master source ticks
	input wire logic src_fixed_tick,
	input wire logic src_tune_tick,
	// Channel pins, index = channel * 8 + pin
	input wire logic [rsdc_pkg::NPINS-1:0] pin_in,
	output logic [rsdc_pkg::NPINS-1:0] pin_out,
	output logic [rsdc_pkg::NPINS-1:0] pin_oe,
	// Backplane trigger lines
	input wire logic [rsdc_pkg::NTRIG-1:0] trig_in,
	output logic [rsdc_pkg::NTRIG-1:0] trig_out,
	output logic [rsdc_pkg::NTRIG-1:0] trig_oe
);
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT} rsdc_state_t;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic chan_q, chan_d;
	rsdc_pkg::rsdc_gen_cfg_t gen_q [3];
	rsdc_pkg::rsdc_gen_cfg_t gen_d [3];
	logic [15:0] trig_sel_q, trig_sel_d;
	logic [15:0] dout_q, dout_d;
	rsdc_pkg::rsdc_pin_cfg_t pcfg_q [rsdc_pkg::NPINS];
	rsdc_pkg::rsdc_pin_cfg_t pcfg_d [rsdc_pkg::NPINS];
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	rsdc_state_t st_q, st_d;
	logic [31:0] sh_q, sh_d;
	logic [15:0] rsh_q, rsh_d, rx_q, rx_d;
	logic [5:0] cnt_q, cnt_d;
	logic sclk_q, sclk_d, mosi_q, mosi_d, rd_q, rd_d, g3p_q, g3p_d;
	logic [rsdc_pkg::NPINS-1:0] pin_out_q, pin_oe_q;
	logic [rsdc_pkg::NTRIG-1:0] trig_out_q, trig_oe_q;
	wire logic [rsdc_pkg::NPINS-1:0] pin_out_d, drv_w;
	wire logic [rsdc_pkg::NTRIG-1:0] trig_out_d, trig_oe_d;
	logic [2:0] gen_clk;
	logic tx_wr, f_in_ready, f_out_valid, f_full, f_empty, pop, miso, g3_rise, g3_fall;
	logic [31:0] f_out_data;
	logic [3:0] midx;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (d & m);
	endfunction

	// ----------------------------------------
	// Command buffer and clock generators
	// ----------------------------------------
	assign tx_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && (wb_adr_i == rsdc_pkg::ADR_TX);

	// Full buffer holds off the bus ack, so software stalls instead of losing words
	rsdc_fifo #(.WIDTH(rsdc_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(tx_wr),
		.in_ready(f_in_ready),
		.in_data(wb_dat_i),
		.out_valid(f_out_valid),
		.out_ready(pop),
		.out_data(f_out_data),
		.full(f_full),
		.empty(f_empty)
	);

	for (genvar g = 0; g < 3; g++) begin : g_gen
		localparam int W = (g == 0) ? rsdc_pkg::GEN1_W : rsdc_pkg::GEN23_W;
		rsdc_divider #(.DIV_W(W)) u_div (
			.clk(clk),
			.nrst(nrst),
			.tick_fixed(src_fixed_tick),
			.tick_tune(src_tune_tick),
			.src_tune(gen_q[g].src_tune),
			.div(gen_q[g].div[W-1:0]),
			.rst_div(W'(1)),
			.clk_out(gen_clk[g])
		);
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_comb begin
		logic [31:0] rv;
		logic [31:0] w;
		logic [3:0] pidx;
		rv = 32'h0;
		w = 32'h0;
		pidx = 4'((wb_adr_i - rsdc_pkg::ADR_PIN0) >> 2);
		chan_d = chan_q;
		gen_d = gen_q;
		trig_sel_d = trig_sel_q;
		dout_d = dout_q;
		pcfg_d = pcfg_q;
		ack_d = 1'b0;
		dat_d = dat_q;
		if (wb_cyc_i && wb_stb_i && !ack_q && (!tx_wr || f_in_ready)) begin
			ack_d = 1'b1;
			if (wb_adr_i == rsdc_pkg::ADR_CTRL) begin
				rv[rsdc_pkg::CTRL_CHAN] = chan_q;
			end else if (wb_adr_i == rsdc_pkg::ADR_STAT) begin
				rv[rsdc_pkg::STAT_BUSY] = st_q != ST_IDLE;
				rv[rsdc_pkg::STAT_EMPTY] = f_empty;
				rv[rsdc_pkg::STAT_FULL] = f_full;
			end else if (wb_adr_i == rsdc_pkg::ADR_RX) begin
				rv[15:0] = rx_q;
			end else if (wb_adr_i == rsdc_pkg::ADR_GEN1) begin
				rv[10:0] = gen_q[0];
			end else if (wb_adr_i == rsdc_pkg::ADR_GEN2) begin
				rv[10:0] = gen_q[1];
			end else if (wb_adr_i == rsdc_pkg::ADR_GEN3) begin
				rv[10:0] = gen_q[2];
			end else if (wb_adr_i == rsdc_pkg::ADR_TRIG) begin
				rv[15:0] = trig_sel_q;
			end else if (wb_adr_i == rsdc_pkg::ADR_DOUT) begin
				rv[15:0] = dout_q;
			end else if (wb_adr_i == rsdc_pkg::ADR_DIN) begin
				rv[15:0] = pin_in;
			end else if (wb_adr_i >= rsdc_pkg::ADR_PIN0 && wb_adr_i <= rsdc_pkg::ADR_PINL) begin
				rv[7:0] = pcfg_q[pidx];
			end
			dat_d = rv;
			w = merge(rv, wb_dat_i, wb_sel_i);
			if (wb_we_i) begin
				if (wb_adr_i == rsdc_pkg::ADR_CTRL) begin
					chan_d = w[rsdc_pkg::CTRL_CHAN];
				end else if (wb_adr_i == rsdc_pkg::ADR_GEN1) begin
					gen_d[0] = w[10:0];
				end else if (wb_adr_i == rsdc_pkg::ADR_GEN2) begin
					gen_d[1] = {w[10], 3'h0, w[6:0]};
				end else if (wb_adr_i == rsdc_pkg::ADR_GEN3) begin
					gen_d[2] = {w[10], 3'h0, w[6:0]};
				end else if (wb_adr_i == rsdc_pkg::ADR_TRIG) begin
					trig_sel_d = w[15:0];
				end else if (wb_adr_i == rsdc_pkg::ADR_DOUT) begin
					dout_d = w[15:0];
				end else if (wb_adr_i >= rsdc_pkg::ADR_PIN0 && wb_adr_i <= rsdc_pkg::ADR_PINL) begin
					pcfg_d[pidx] = w[7:0];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chan_q <= 1'b0;
			gen_q[0] <= rsdc_pkg::GEN_RST;
			gen_q[1] <= rsdc_pkg::GEN_RST;
			gen_q[2] <= rsdc_pkg::GEN3_RST;
			trig_sel_q <= 16'h0000;
			dout_q <= 16'h0000;
			for (int i = 0; i < rsdc_pkg::NPINS; i++) begin
				pcfg_q[i] <= rsdc_pkg::PIN_CFG_RST;
			end
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			chan_q <= chan_d;
			gen_q <= gen_d;
			trig_sel_q <= trig_sel_d;
			dout_q <= dout_d;
			pcfg_q <= pcfg_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	// ----------------------------------------
	// Serial master
	// ----------------------------------------
	assign midx = {chan_q, rsdc_pkg::PIN_MISO};
	assign miso = !pcfg_q[midx].drive && pin_in[midx];
	assign g3_rise = gen_clk[2] && !g3p_q;
	assign g3_fall = !gen_clk[2] && g3p_q;

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		rsh_d = rsh_q;
		cnt_d = cnt_q;
		sclk_d = sclk_q;
		mosi_d = mosi_q;
		rd_d = rd_q;
		rx_d = rx_q;
		g3p_d = gen_clk[2];
		pop = 1'b0;
		case (st_q)
			ST_IDLE: begin
				sclk_d = 1'b0;
				if (f_out_valid) begin
					pop = 1'b1;
					sh_d = f_out_data;
					mosi_d = f_out_data[rsdc_pkg::WORD_W-1];
					rd_d = f_out_data[rsdc_pkg::CMD_RW];
					cnt_d = 6'h00;
					st_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (g3_rise && cnt_q != rsdc_pkg::SPI_BITS) begin
					sclk_d = 1'b1;
					rsh_d = {rsh_q[14:0], miso};
					cnt_d = cnt_q + 6'h01;
				end else if (g3_fall && sclk_q) begin
					sclk_d = 1'b0;
					if (cnt_q == rsdc_pkg::SPI_BITS) begin
						st_d = ST_IDLE;
						if (rd_q) begin
							rx_d = rsh_q;
						end
					end else begin
						sh_d = {sh_q[30:0], 1'b0};
						mosi_d = sh_q[30];
					end
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
			sh_q <= 32'h0;
			rsh_q <= 16'h0000;
			cnt_q <= 6'h00;
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
			rd_q <= 1'b0;
			rx_q <= 16'h0000;
			g3p_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			rsh_q <= rsh_d;
			cnt_q <= cnt_d;
			sclk_q <= sclk_d;
			mosi_q <= mosi_d;
			rd_q <= rd_d;
			rx_q <= rx_d;
			g3p_q <= g3p_d;
		end
	end

	// ----------------------------------------
	// Pin and trigger routing
	// ----------------------------------------
	for (genvar i = 0; i < rsdc_pkg::NPINS; i++) begin : g_pin
		localparam int P = i % rsdc_pkg::NPCH;
		logic o;
		always_comb begin
			case (pcfg_q[i].osel)
				rsdc_pkg::OSEL_SCLK: o = (P == rsdc_pkg::PIN_SCLK) ? sclk_q : dout_q[i];
				rsdc_pkg::OSEL_MOSI: o = (P == rsdc_pkg::PIN_MOSI) ? mosi_q : dout_q[i];
				rsdc_pkg::OSEL_TRIG: o = trig_in[pcfg_q[i].tsel];
				rsdc_pkg::OSEL_GEN1: o = gen_clk[0];
				rsdc_pkg::OSEL_GEN2: o = gen_clk[1];
				rsdc_pkg::OSEL_GEN3: o = gen_clk[2];
				default: o = dout_q[i];
			endcase
		end
		assign pin_out_d[i] = o;
		assign drv_w[i] = pcfg_q[i].drive;
	end

	for (genvar t = 0; t < rsdc_pkg::NTRIG; t++) begin : g_trig
		logic hit, val, o, oe;
		always_comb begin
			logic [1:0] gsel;
			hit = 1'b0;
			val = 1'b0;
			gsel = trig_sel_q[2*t +: 2];
			for (int k = 0; k < rsdc_pkg::NPINS; k++) begin
				if (!pcfg_q[k].drive && pcfg_q[k].trig_en && pcfg_q[k].tsel == 3'(t)) begin
					hit = 1'b1;
					val = val | pin_in[k];
				end
			end
			// Generator selection wins over pins routed to the same line
			oe = (gsel != 2'h0) || hit;
			case (gsel)
				2'h1: o = gen_clk[0];
				2'h2: o = gen_clk[1];
				2'h3: o = gen_clk[2];
				default: o = val;
			endcase
		end
		assign trig_out_d[t] = o;
		assign trig_oe_d[t] = oe;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_out_q <= '0;
			pin_oe_q <= '0;
			trig_out_q <= '0;
			trig_oe_q <= '0;
		end else begin
			pin_out_q <= pin_out_d;
			pin_oe_q <= drv_w;
			trig_out_q <= trig_out_d;
			trig_oe_q <= trig_oe_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;
	assign trig_out = trig_out_q;
	assign trig_oe = trig_oe_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_sclk_idle;
		st_q == ST_IDLE |-> !sclk_q;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock high while idle");

	property p_mosi_fall;
		$changed(mosi_q) && $past(st_q) == ST_SHIFT |-> $fell(sclk_q);
	endproperty
	a_mosi_fall: assert property (p_mosi_fall) else $error("write line moved off a fall");

	property p_sample_rise;
		$changed(rsh_q) |-> $rose(sclk_q);
	endproperty
	a_sample_rise: assert property (p_sample_rise) else $error("readback sampled off a rise");

	property p_pulses;
		st_q == ST_IDLE && $past(st_q) == ST_SHIFT |-> $past(cnt_q) == rsdc_pkg::SPI_BITS;
	endproperty
	a_pulses: assert property (p_pulses) else $error("transaction pulse count not 32");

	property p_busy_start;
		st_q == ST_IDLE && f_out_valid |=> (st_q == ST_SHIFT)[*4];
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy not raised on start");

	property p_gen3_rst;
		$rose(nrst) |-> gen_q[2] == rsdc_pkg::GEN3_RST;
	endproperty
	a_gen3_rst: assert property (p_gen3_rst) else $error("third generator not at reset rate");

	property p_spi_pin;
		pcfg_q[13].osel == rsdc_pkg::OSEL_SCLK |=> pin_out_q[13] == $past(dout_q[13]);
	endproperty
	a_spi_pin: assert property (p_spi_pin) else $error("serial clock on a non-clock pin");

	property p_dir;
		pcfg_q[8].drive |=> pin_oe_q[8];
	endproperty
	a_dir: assert property (p_dir) else $error("output pin not driven");

	c_read: cover property (st_q == ST_SHIFT && rd_q ##1 st_q == ST_IDLE);
	c_stall: cover property (tx_wr && !f_in_ready);
	c_trig: cover property (trig_oe_q != 8'h00);
endmodule

// ---- verif/rsdc_remote.sv ----
module rsdc_remote (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Serial lines as seen at the pins
	input wire logic sclk,
	input wire logic mosi,
	input wire logic [31:0] resp,
	output logic miso,
	// Captured words
	output logic [31:0] word,
	output logic done,
	output int rises
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sclk_q;
	logic busy;
	logic [31:0] sh;
	int nfall;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclk_q <= 1'b0;
			busy <= 1'b0;
			sh <= 32'h0;
			nfall <= 0;
			rises <= 0;
			done <= 1'b0;
			miso <= 1'b0;
			word <= 32'h0;
		end else begin
			sclk_q <= sclk;
			done <= 1'b0;
			// Released line must not look like held data
			if (!busy) begin
				miso <= ~miso;
			end
			if (sclk && !sclk_q) begin
				sh <= {sh[30:0], mosi};
				rises <= rises + 1;
				busy <= 1'b1;
			end
			if (!sclk && sclk_q) begin
				if (nfall == 31) begin
					word <= sh;
					done <= 1'b1;
					nfall <= 0;
					busy <= 1'b0;
				end else begin
					miso <= resp[30-nfall];
					nfall <= nfall + 1;
				end
			end
		end
	end
endmodule

// ---- verif/tb_remote_spi_dio_clock_master.sv ----
module tb_remote_spi_dio_clock_master;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic src_fixed_tick = 1'b0;
	logic src_tune_tick = 1'b0;
	logic [15:0] ext = 16'h0;
	logic [15:0] pin_in;
	logic [15:0] pin_out;
	logic [15:0] pin_oe;
	logic [7:0] trig_in = 8'h0;
	logic [7:0] trig_out;
	logic [7:0] trig_oe;
	logic [31:0] resp = 32'h0;
	logic miso;
	logic [31:0] word;
	logic done;
	int rises;
	int checks = 0;
	int miscompares = 0;
	int seed = 72;
	logic [31:0] exp_q[$];
	logic [31:0] got_q[$];
	logic op = 1'b0;
	logic mp = 1'b0;
	logic [7:0] tp = 8'h0;
	// ----------------------------------------
	// Design, far side and wire levels
	// ----------------------------------------
	assign pin_in = (pin_out & pin_oe) | ({ext[15:3], miso, ext[1:0]} & ~pin_oe);
	rsdc_top #(.FIFO_DEPTH(16)) rsdc_top_i (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.src_fixed_tick(src_fixed_tick), .src_tune_tick(src_tune_tick), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .trig_in(trig_in), .trig_out(trig_out),
		.trig_oe(trig_oe));
	// Undriven pins read low at the far end
	rsdc_remote rsdc_remote_i (.clk(clk), .nrst(nrst), .sclk(pin_out[0] & pin_oe[0]),
		.mosi(pin_out[1] & pin_oe[1]),
		.resp(resp), .miso(miso), .word(word), .done(done), .rises(rises));
	always #5 clk = ~clk;
	// Tunable source scaled to clk rate, fixed source at half of it
	always @(posedge clk) begin
		src_tune_tick <= 1'b1;
		src_fixed_tick <= ~src_fixed_tick;
		trig_in <= 8'($random(seed));
		if (done) begin
			got_q.push_back(word);
		end
		if (pin_oe[1] === 1'b1 && op === 1'b1 && pin_out[1] !== mp) begin
			chk({31'h0, pin_out[0]}, 32'h0);
		end
		op <= pin_oe[1];
		mp <= pin_out[1];
		tp <= trig_in;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		checks++;
		if (seen !== expv) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] expv);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, expv);
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] dout;
		logic [7:0] drv;
		logic [15:0] eo;
		logic [31:0] q;
		logic [4:0] p;
		logic [4:0] c;
		int n[5];
		int k;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rc(rsdc_pkg::ADR_STAT, 32'h2);
		rc(rsdc_pkg::ADR_GEN3, 32'(rsdc_pkg::GEN3_RST));
		rc(rsdc_pkg::ADR_GEN1, 32'(rsdc_pkg::GEN_RST));
		rc(8'hfc, 32'h0);
		wr(rsdc_pkg::ADR_GEN1, 32'h7ff);
		wr(rsdc_pkg::ADR_GEN2, 32'h7ff);
		rc(rsdc_pkg::ADR_GEN1, 32'h7ff);
		rc(rsdc_pkg::ADR_GEN2, 32'h47f);
		wr(rsdc_pkg::ADR_CTRL, 32'h1);
		rc(rsdc_pkg::ADR_CTRL, 32'h1);
		wr(rsdc_pkg::ADR_CTRL, 32'h0);
		$display("Test registers done");
		// Channel two pins, one serial select on a non-serial pin
		dout = 16'($random(seed));
		drv = 8'($random(seed));
		ext <= 16'($random(seed));
		for (int i = 0; i < 8; i++) begin
			wr(rsdc_pkg::ADR_PIN0 + 8'(4 * (i + 8)), {30'h0, i == 5, drv[i]});
		end
		wr(rsdc_pkg::ADR_DOUT, {16'h0, dout});
		repeat (3) @(posedge clk);
		eo = {drv, 8'h00};
		chk({16'h0, pin_oe}, {16'h0, eo});
		chk({16'h0, pin_out & pin_oe}, {16'h0, dout & eo});
		wb(1'b0, rsdc_pkg::ADR_DIN, 32'h0, q);
		chk(q & 32'hfffb, {16'h0, ((eo & dout) | (~eo & ext)) & 16'hfffb});
		$display("Test pins done");
		// Generated clocks on pins and two trigger lines
		wr(rsdc_pkg::ADR_GEN1, 32'h1);
		wr(rsdc_pkg::ADR_PIN0 + 8'd32, 32'h9);
		wr(rsdc_pkg::ADR_PIN0 + 8'd36, 32'hd);
		wr(rsdc_pkg::ADR_GEN2, 32'h402);
		wr(rsdc_pkg::ADR_PIN0 + 8'd40, 32'hb);
		wr(rsdc_pkg::ADR_PIN0 + 8'd44, 32'h17);
		wr(rsdc_pkg::ADR_TRIG, 32'h13);
		wr(rsdc_pkg::ADR_PIN0 + 8'd48, 32'h90);
		repeat (4) @(posedge clk);
		n = '{0, 0, 0, 0, 0};
		p = {pin_out[8], pin_out[9], trig_out[0], pin_out[10], trig_out[2]};
		repeat (64) begin
			@(posedge clk);
			c = {pin_out[8], pin_out[9], trig_out[0], pin_out[10], trig_out[2]};
			for (int b = 0; b < 5; b++) if (c[b] !== p[b]) n[b]++;
			p = c;
		end
		chk(32'(n[4]), 32'd32);
		chk(32'(n[3]), 32'd16);
		chk(32'(n[2]), 32'd16);
		chk(32'(n[1]), 32'd32);
		chk(32'(n[0]), 32'd32);
		for (int v = 0; v < 2; v++) begin
			ext[12] <= v[0];
			repeat (4) @(posedge clk);
			chk({31'h0, trig_out[1]}, 32'(v));
			chk({31'h0, pin_out[11]}, {31'h0, tp[1]});
		end
		$display("Test clocks done");
		// Serial link: fill the queue until full, then drain
		wr(rsdc_pkg::ADR_PIN0, 32'h3);
		wr(rsdc_pkg::ADR_PIN0 + 8'd4, 32'h5);
		resp <= $random(seed);
		for (k = 0; k < 18; k++) begin
			q = $random(seed);
			if (k == 17) q[31] = 1'b1;
			exp_q.push_back(q);
			wr(rsdc_pkg::ADR_TX, q);
		end
		rc(rsdc_pkg::ADR_STAT, 32'h5);
		k = 0;
		while (got_q.size() < 18 && k < 20000) begin
			@(posedge clk);
			k++;
		end
		chk(32'(got_q.size()), 32'd18);
		foreach (got_q[i]) chk(got_q[i], exp_q[i]);
		chk(32'(rises), 32'd576);
		rc(rsdc_pkg::ADR_RX, {16'h0, resp[15:0]});
		rc(rsdc_pkg::ADR_STAT, 32'h2);
		k = 0;
		p[0] = pin_out[0];
		repeat (200) begin
			@(posedge clk);
			if (pin_out[0] !== p[0]) k++;
			p[0] = pin_out[0];
		end
		chk(32'(k), 32'h0);
		$display("Test serial done");
		report_and_stop;
	end
	// Whole run needs about 5000 cycles
	initial begin
		#400000;
		miscompares++;
		report_and_stop;
	end
endmodule
